// *** test/bmd_ctrl_tb.sv ***
// self-checking bench of the bus-master download control block
`timescale 1ns/1ps
module bmd_ctrl_tb
    import bmd_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic last_err;
    logic [31:0] rd;
    logic [31:0] rd0;
    bmd_engine_s engine_in;
    bmd_ctrl_s ctrl_out;
    logic irq;
    int err_total = 0;
    int total_checks = 0;
    int rst_seen = 0;

    bmd_ctrl i_bmd_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .engine_in(engine_in), .ctrl_out(ctrl_out), .irq(irq));
    bmd_engine_model i_bmd_engine_model (.pclk(pclk), .presetn(presetn), .ctrl_in(ctrl_out),
        .engine_out(engine_in));

    initial begin
        forever #12.5 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        if (ctrl_out.download_reset === 1'b1) begin
            rst_seen++;
        end
    end

    ////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 16) begin
            err_total++;
            report_and_stop();
        end
    endtask

    task automatic wait_irq(input int lim);
        int n;
        n = 0;
        while (irq !== 1'b1 && n < lim) begin
            @(posedge pclk);
            n++;
        end
        if (n >= lim) begin
            err_total++;
            report_and_stop();
        end
    endtask

    ////////////////////////////////////////
    task automatic t_regs();
        apb(0, BURST_THR_ADDR, 0);
        chk(rd, 32'h8);
        apb(0, LIST_PTR_ADDR, 0);
        chk(rd, 32'h0);
        chk(ctrl_out.list_empty, 1);
        apb(1, BURST_THR_ADDR, 32'h0);
        apb(0, BURST_THR_ADDR, 0);
        chk(rd, 32'h8);
        apb(1, BURST_THR_ADDR, 32'hf3);
        apb(0, BURST_THR_ADDR, 0);
        chk(rd, 32'h3);
        apb(1, LIST_PTR_ADDR, 32'h1000_0007);
        apb(0, LIST_PTR_ADDR, 0);
        chk(rd, 32'h1000_0000);
        apb(1, LIST_PTR_ADDR, 32'h2000_0000);
        apb(0, LIST_PTR_ADDR, 0);
        chk(rd, 32'h1000_0000);
        i_bmd_engine_model.load_ptr(32'h3000_000f);
        apb(0, LIST_PTR_ADDR, 0);
        chk(rd, 32'h3000_0008);
        chk(ctrl_out.list_pointer, 32'h3000_0008);
        chk(ctrl_out.list_empty, 0);
        apb(0, 12'h3fc, 0);
        chk({rd[30:0], last_err}, 32'h1);
    endtask

    task automatic t_request();
        logic [7:0] fr [3] = '{8'h3, 8'h4, 8'h3};
        for (int i = 0; i < 3; i++) begin
            i_bmd_engine_model.set_io(fr[i], i == 2, 0, 0);
            repeat (3) @(posedge pclk);
            chk(ctrl_out.download_bus_request, i != 0);
        end
        apb(0, DMA_CTRL_ADDR, 0);
        chk(rd[ACTIVE_BIT], 1);
        apb(1, COMMAND_ADDR, 32'h4);
        repeat (2) @(posedge pclk);
        chk(ctrl_out.download_stall, 1);
        apb(0, DMA_CTRL_ADDR, 0);
        chk(rd[ACTIVE_BIT], 0);
        apb(1, COMMAND_ADDR, 32'h10);
        apb(1, COMMAND_ADDR, 32'h8);
        chk(rst_seen, 1);
    endtask

    task automatic t_mwi();
        i_bmd_engine_model.set_io(3, 1, 1, 0);
        apb(1, DMA_CTRL_ADDR, 32'h0);
        chk(ctrl_out.use_mwi, 1);
        apb(1, DMA_CTRL_ADDR, 32'h0010_0000);
        apb(0, DMA_CTRL_ADDR, 0);
        chk(rd & 32'h0010_0000, 32'h0010_0000);
        chk(ctrl_out.use_mwi, 0);
        apb(1, DMA_CTRL_ADDR, 32'h0);
    endtask

    task automatic t_abort();
        for (int k = 0; k < 2; k++) begin
            i_bmd_engine_model.pulse_abort(k);
            repeat (3) @(posedge pclk);
            apb(0, DMA_CTRL_ADDR, 0);
            chk(rd & 32'hc000_0000, 32'h4000_0000 << k);
            chk({ctrl_out.transfers_enabled, ctrl_out.download_bus_request}, 0);
            apb(1, COMMAND_ADDR, 32'h3);
            apb(0, DMA_CTRL_ADDR, 0);
            chk(rd & 32'hc000_0000, 32'h4000_0000 << k);
            apb(1, COMMAND_ADDR, 32'h1);
            apb(0, DMA_CTRL_ADDR, 0);
            chk(rd & 32'hc000_0000, 0);
            chk(ctrl_out.transfers_enabled, 1);
        end
        chk(irq, 0);
        apb(0, IRQ_STATUS_ADDR, 0);
        chk(rd, 32'h6);
        apb(1, IRQ_MASK_ADDR, 32'h2);
        repeat (2) @(posedge pclk);
        chk(irq, 1);
        apb(1, IRQ_STATUS_ADDR, 32'h6);
        repeat (2) @(posedge pclk);
        chk(irq, 0);
    endtask

    task automatic t_timer();
        for (int r = 1; r >= 0; r--) begin
            apb(1, DMA_CTRL_ADDR, r << RATE_BIT);
            repeat (330) @(posedge pclk);
            apb(0, FREE_TIMER_ADDR, 0);
            rd0 = rd;
            repeat (r ? 77 : 317) @(posedge pclk);
            apb(0, FREE_TIMER_ADDR, 0);
            chk((rd - rd0) & 32'hff, 32'h1);
        end
    endtask

    task automatic t_countdown();
        apb(1, IRQ_MASK_ADDR, 32'h1);
        apb(1, DMA_CTRL_ADDR, 32'h100);
        apb(1, COUNTDOWN_ADDR, 32'h2);
        apb(0, DMA_CTRL_ADDR, 0);
        chk(rd[ARMED_BIT], 1);
        wait_irq(400);
        apb(0, DMA_CTRL_ADDR, 0);
        chk(rd[ARMED_BIT], 0);
        apb(0, IRQ_STATUS_ADDR, 0);
        chk(rd, 32'h1);
        apb(1, IRQ_STATUS_ADDR, 32'h1);
        apb(1, COUNTDOWN_ADDR, 32'h5);
        apb(1, COUNTDOWN_ADDR, 32'h0);
        apb(0, DMA_CTRL_ADDR, 0);
        chk(rd[ARMED_BIT], 0);
        apb(1, DMA_CTRL_ADDR, 32'h300);
        apb(1, COUNTDOWN_ADDR, 32'h1);
        repeat (200) @(posedge pclk);
        chk(irq, 0);
        i_bmd_engine_model.set_io(3, 0, 0, 1);
        wait_irq(200);
        apb(0, DMA_CTRL_ADDR, 0);
        chk(rd[DONE_BIT], 1);
    endtask

    ////////////////////////////////////////
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_request();
        t_mwi();
        t_abort();
        t_timer();
        t_countdown();
        report_and_stop();
    end
endmodule

// *** test/bmd_engine_model.sv ***
// engine-side model of the download and bus-master engines
`timescale 1ns/1ps
module bmd_engine_model
    import bmd_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control in, status out
    input wire bmd_ctrl_s ctrl_in,
    output bmd_engine_s engine_out
);
    ////////////////////////////////////////
    bmd_engine_s drive = '0;

    // engine busy while bus requested and not stalled
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            engine_out <= '0;
        end else begin
            engine_out <= drive;
            engine_out.download_active <= ctrl_in.download_bus_request & ~ctrl_in.download_stall;
        end
    end

    ////////////////////////////////////////
    task automatic set_io(input logic [FREE_W-1:0] free, input logic pri, input logic mwi, input logic done);
        @(posedge pclk);
        drive.fifo_free_units <= free;
        drive.priority_request <= pri;
        drive.mwi_wanted <= mwi;
        drive.download_done <= done;
    endtask

    task automatic pulse_abort(input logic master);
        @(posedge pclk);
        drive.target_abort_evt <= ~master;
        drive.master_abort_evt <= master;
        @(posedge pclk);
        drive.target_abort_evt <= 1'b0;
        drive.master_abort_evt <= 1'b0;
    endtask

    task automatic load_ptr(input logic [31:0] value);
        @(posedge pclk);
        drive.ptr_load <= 1'b1;
        drive.ptr_value <= value;
        @(posedge pclk);
        drive.ptr_load <= 1'b0;
    endtask
endmodule

// *** verilog/bmd_ctrl.sv ***
// bus-master download control, status and thresholds with apb registers
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
module bmd_ctrl
    import bmd_pkg::*;
(
    // apb slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // engine side
    input wire bmd_engine_s engine_in,
    output bmd_ctrl_s ctrl_out,
    // interrupt
    output logic irq
);
    ////////////////////////////////////////////////////////////////
    // register state
    logic armed_reg;
    logic rate_reg;
    logic mode_reg;
    logic mwi_defeat_reg;
    logic target_abort_reg;
    logic master_abort_reg;
    logic [31:0] list_ptr_reg;
    logic [THR_W-1:0] burst_thr_reg;
    logic [IRQ_W-1:0] status_reg;
    logic [IRQ_W-1:0] status_next;
    logic [IRQ_W-1:0] mask_reg;
    logic [TIMER_W-1:0] count_reg;
    logic [TIMER_W-1:0] count_next;
    logic [TIMER_W-1:0] free_timer_reg;
    logic stall_reg;
    logic tick;

    ////////////////////////////////////////////////////////////////
    // apb decode, one wait-free access phase
    wire setup = psel && !penable;
    wire wr_en = psel && penable && pwrite && pready;
    wire hit_ctrl = paddr == DMA_CTRL_ADDR;
    wire hit_ptr = paddr == LIST_PTR_ADDR;
    wire hit_thr = paddr == BURST_THR_ADDR;
    wire hit_stat = paddr == IRQ_STATUS_ADDR;
    wire hit_mask = paddr == IRQ_MASK_ADDR;
    wire hit_count = paddr == COUNTDOWN_ADDR;
    wire hit_cmd = paddr == COMMAND_ADDR;
    wire hit_free = paddr == FREE_TIMER_ADDR;
    wire mapped = hit_ctrl | hit_ptr | hit_thr | hit_stat | hit_mask | hit_count | hit_cmd | hit_free;

    wire [31:0] ctrl_word = (32'(target_abort_reg) << TARGET_ABORT_BIT)
                          | (32'(master_abort_reg) << MASTER_ABORT_BIT)
                          | (32'(mwi_defeat_reg) << MWI_DEFEAT_BIT)
                          | (32'(mode_reg) << MODE_BIT)
                          | (32'(rate_reg) << RATE_BIT)
                          | (32'(engine_in.download_active) << ACTIVE_BIT)
                          | (32'(armed_reg) << ARMED_BIT)
                          | (32'(engine_in.download_done) << DONE_BIT);
    wire [31:0] rd_mux = hit_ctrl ? ctrl_word :
                         hit_ptr ? list_ptr_reg :
                         hit_thr ? 32'(burst_thr_reg) :
                         hit_stat ? 32'(status_reg) :
                         hit_mask ? 32'(mask_reg) :
                         hit_count ? 32'(count_reg) :
                         hit_free ? 32'(free_timer_reg) : 32'h0000_0000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else begin
            pready <= setup;
            pslverr <= setup && !mapped;
            prdata <= (setup && !pwrite) ? rd_mux : prdata;
        end
    end

    ////////////////////////////////////////////////////////////////
    // commands and control writes
    wire wr_ctrl = wr_en && hit_ctrl;
    wire wr_count = wr_en && hit_count;
    wire wr_cmd = wr_en && hit_cmd;
    wire cmd_global = wr_cmd && pwdata[CMD_GLOBAL_RESET_BIT];
    wire abort_clear = cmd_global && !pwdata[CMD_ENGINES_MASK_BIT];
    wire cmd_stall = wr_cmd && pwdata[CMD_STALL_BIT];
    wire cmd_unstall = wr_cmd && pwdata[CMD_UNSTALL_BIT];
    wire cmd_dn_reset = wr_cmd && pwdata[CMD_DOWNLOAD_RESET_BIT];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rate_reg <= 1'b0;
            mode_reg <= 1'b0;
            mwi_defeat_reg <= 1'b0;
            mask_reg <= '0;
            stall_reg <= 1'b0;
        end else begin
            rate_reg <= wr_ctrl ? pwdata[RATE_BIT] : rate_reg;
            mode_reg <= wr_ctrl ? pwdata[MODE_BIT] : mode_reg;
            mwi_defeat_reg <= wr_ctrl ? pwdata[MWI_DEFEAT_BIT] : mwi_defeat_reg;
            mask_reg <= (wr_en && hit_mask) ? pwdata[IRQ_W-1:0] : mask_reg;
            stall_reg <= cmd_stall ? 1'b1 : (cmd_unstall ? 1'b0 : stall_reg);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            target_abort_reg <= 1'b0;
            master_abort_reg <= 1'b0;
        end else begin
            target_abort_reg <= engine_in.target_abort_evt || (target_abort_reg && !abort_clear);
            master_abort_reg <= engine_in.master_abort_evt || (master_abort_reg && !abort_clear);
        end
    end

    ////////////////////////////////////////////////////////////////
    // countdown and free-running timers
    bmd_tick_gen u_tick (
        .pclk(pclk),
        .presetn(presetn),
        .rate_fast(rate_reg),
        .tick(tick)
    );

    wire count_run = (count_reg != '0) && (!mode_reg || engine_in.download_done);
    wire expire = tick && count_run && (count_reg == 16'h0001);
    wire req_set = expire && armed_reg;
    assign count_next = wr_count ? pwdata[TIMER_W-1:0] : (tick && count_run) ? count_reg - 16'h0001 : count_reg;

    // arm on nonzero write, disarm on request
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            armed_reg <= 1'b0;
            count_reg <= '0;
            free_timer_reg <= '0;
        end else begin
            armed_reg <= wr_count ? (pwdata[TIMER_W-1:0] != '0) : (armed_reg && !req_set);
            count_reg <= count_next;
            free_timer_reg <= tick ? free_timer_reg + 16'h0001 : free_timer_reg;
        end
    end

    ////////////////////////////////////////////////////////////////
    // interrupt status, write one to clear, set wins
    wire [IRQ_W-1:0] status_set = {engine_in.master_abort_evt, engine_in.target_abort_evt, req_set};
    wire [IRQ_W-1:0] status_clr = (wr_en && hit_stat) ? pwdata[IRQ_W-1:0] : '0;
    assign status_next = status_set | (status_reg & ~status_clr);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_reg <= '0;
            irq <= 1'b0;
        end else begin
            status_reg <= status_next;
            irq <= |(status_next & mask_reg);
        end
    end

    ////////////////////////////////////////////////////////////////
    // list pointer and burst threshold
    // host write only when pointer is zero
    wire ptr_host_wr = wr_en && hit_ptr && (list_ptr_reg == '0);
    wire ptr_eng_wr = engine_in.ptr_load && (engine_in.ptr_value != '0);
    wire [31:0] ptr_wdata = ptr_eng_wr ? engine_in.ptr_value : pwdata;
    wire [31:0] ptr_next = (ptr_host_wr || ptr_eng_wr) ? {ptr_wdata[31:PTR_ALIGN_W], 3'h0} : list_ptr_reg;
    wire thr_wr = wr_en && hit_thr && (pwdata[THR_W-1:0] != '0);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            list_ptr_reg <= '0;
            burst_thr_reg <= BURST_THR_RESET;
        end else begin
            list_ptr_reg <= ptr_next;
            burst_thr_reg <= thr_wr ? pwdata[THR_W-1:0] : burst_thr_reg;
        end
    end

    ////////////////////////////////////////////////////////////////
    // engine control outputs
    wire fatal = target_abort_reg || master_abort_reg || engine_in.target_abort_evt || engine_in.master_abort_evt;
    wire room = engine_in.fifo_free_units > FREE_W'(burst_thr_reg);
    wire want_bus = (room || engine_in.priority_request) && (ptr_next != '0);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_out <= '{list_empty: 1'b1, default: '0};
        end else begin
            ctrl_out.download_bus_request <= want_bus && !fatal && !stall_reg;
            ctrl_out.use_mwi <= engine_in.mwi_wanted && !mwi_defeat_reg;
            ctrl_out.transfers_enabled <= !fatal;
            ctrl_out.download_stall <= stall_reg;
            ctrl_out.download_reset <= cmd_dn_reset;
            ctrl_out.list_empty <= ptr_next == '0;
            ctrl_out.list_pointer <= ptr_next;
        end
    end

    ////////////////////////////////////////////////////////////////
    // checks
    sequence count_write_nz;
        wr_count && pwdata[TIMER_W-1:0] != '0;
    endsequence
    sequence ctrl_read;
        psel && !penable && !pwrite && hit_ctrl;
    endsequence

    arm_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(status_reg[IRQ_COUNTDOWN_BIT]) |-> $past(armed_reg) && $past(count_reg) == 16'h0001)
        else $error("countdown request without arming");
    arm_cycle_a: assert property (@(posedge pclk) disable iff (!presetn)
        count_write_nz |=> armed_reg ##1 (armed_reg || $past(req_set) || $past(wr_count)))
        else $error("armed bit not set by nonzero write");
    disarm_a: assert property (@(posedge pclk) disable iff (!presetn)
        req_set && !wr_count |=> !armed_reg && status_reg[IRQ_COUNTDOWN_BIT])
        else $error("armed bit not cleared on request");
    active_view_a: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_read ##1 1'b1 |-> prdata[ACTIVE_BIT] == $past(engine_in.download_active))
        else $error("download active bit misreported");
    mode_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        mode_reg && !engine_in.download_done && !wr_count |=> count_reg == $past(count_reg))
        else $error("countdown ran before download done");
    mwi_block_a: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_out.use_mwi |-> !$past(mwi_defeat_reg))
        else $error("write-invalidate used while defeated");
    target_fatal_a: assert property (@(posedge pclk) disable iff (!presetn)
        engine_in.target_abort_evt |=> target_abort_reg && !ctrl_out.download_bus_request)
        else $error("target abort not fatal");
    master_fatal_a: assert property (@(posedge pclk) disable iff (!presetn)
        engine_in.master_abort_evt |=> master_abort_reg ##1 !ctrl_out.download_bus_request)
        else $error("master abort not fatal");
    abort_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        abort_clear && !engine_in.target_abort_evt && !engine_in.master_abort_evt
        |=> !target_abort_reg && !master_abort_reg)
        else $error("global reset left abort flags");
    bus_req_a: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_out.download_bus_request
        |-> $past(engine_in.fifo_free_units > FREE_W'(burst_thr_reg) || engine_in.priority_request))
        else $error("bus request below threshold");
    ptr_lock_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && hit_ptr && list_ptr_reg != '0 && !ptr_eng_wr |=> $stable(list_ptr_reg))
        else $error("pointer written while nonzero");
    ptr_align_a: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_out.list_pointer[PTR_ALIGN_W-1:0] == 3'h0 && ctrl_out.list_empty == (ctrl_out.list_pointer == '0))
        else $error("pointer misaligned or empty flag wrong");
    thr_nonzero_a: assert property (@(posedge pclk) disable iff (!presetn)
        burst_thr_reg != '0)
        else $error("burst threshold became zero");
endmodule

// *** verilog/bmd_pkg.sv ***
// constants and carriers of the bus-master download control block
// Summary of operation
// - countdown expiry requests interrupt only when armed
// - armed clears on request or zero write
// - download active status bit is read-only
// - timers tick every 8 or 2 us
// - countdown mode waits for download done
// - write-invalidate defeat blocks that command
// - target abort sets fatal flag, blocks transfers
// - master abort sets fatal flag, blocks transfers
// - global reset without mask clears abort flags
// - request bus when free space exceeds threshold
// - priority request overrides burst threshold
// - threshold nonzero, defaults to 8 units
// - 32-bit read/write download list pointer
// - zero pointer means nothing left to download
// - host pointer writes ignored while pointer nonzero
// - pointer low three bits always zero
package bmd_pkg;
    localparam int ADDR_W = 12;
    // register indices; byte address is index times four
    localparam logic [9:0] DMA_CTRL_IDX = 10'h020;
    localparam logic [9:0] LIST_PTR_IDX = 10'h024;
    localparam logic [9:0] BURST_THR_IDX = 10'h041;
    localparam logic [9:0] IRQ_STATUS_IDX = 10'h050;
    localparam logic [9:0] IRQ_MASK_IDX = 10'h051;
    localparam logic [9:0] COUNTDOWN_IDX = 10'h052;
    localparam logic [9:0] COMMAND_IDX = 10'h053;
    localparam logic [9:0] FREE_TIMER_IDX = 10'h054;
    localparam logic [11:0] DMA_CTRL_ADDR = {DMA_CTRL_IDX, 2'b00};
    localparam logic [11:0] LIST_PTR_ADDR = {LIST_PTR_IDX, 2'b00};
    localparam logic [11:0] BURST_THR_ADDR = {BURST_THR_IDX, 2'b00};
    localparam logic [11:0] IRQ_STATUS_ADDR = {IRQ_STATUS_IDX, 2'b00};
    localparam logic [11:0] IRQ_MASK_ADDR = {IRQ_MASK_IDX, 2'b00};
    localparam logic [11:0] COUNTDOWN_ADDR = {COUNTDOWN_IDX, 2'b00};
    localparam logic [11:0] COMMAND_ADDR = {COMMAND_IDX, 2'b00};
    localparam logic [11:0] FREE_TIMER_ADDR = {FREE_TIMER_IDX, 2'b00};
    // control register fields
    localparam int DONE_BIT = 4;
    localparam int ARMED_BIT = 6;
    localparam int ACTIVE_BIT = 7;
    localparam int RATE_BIT = 8;
    localparam int MODE_BIT = 9;
    localparam int MWI_DEFEAT_BIT = 20;
    localparam int TARGET_ABORT_BIT = 30;
    localparam int MASTER_ABORT_BIT = 31;
    // interrupt status and mask fields
    localparam int IRQ_W = 3;
    localparam int IRQ_COUNTDOWN_BIT = 0;
    localparam int IRQ_TARGET_BIT = 1;
    localparam int IRQ_MASTER_BIT = 2;
    // command register fields
    localparam int CMD_GLOBAL_RESET_BIT = 0;
    localparam int CMD_ENGINES_MASK_BIT = 1;
    localparam int CMD_STALL_BIT = 2;
    localparam int CMD_UNSTALL_BIT = 3;
    localparam int CMD_DOWNLOAD_RESET_BIT = 4;
    // widths and reset values
    localparam int TIMER_W = 16;
    localparam int THR_W = 4;
    localparam int FREE_W = 8;
    localparam int PTR_ALIGN_W = 3;
    localparam logic [THR_W-1:0] BURST_THR_RESET = 4'h8;
    // timer tick periods
    localparam int CLK_PERIOD_NS = 25;
    localparam int TICK_SLOW_NS = 8000;
    localparam int TICK_FAST_NS = 2000;
    localparam int PRESCALE_W = 9;
    localparam logic [PRESCALE_W-1:0] TICK_SLOW_CYC = PRESCALE_W'(TICK_SLOW_NS / CLK_PERIOD_NS);
    localparam logic [PRESCALE_W-1:0] TICK_FAST_CYC = PRESCALE_W'(TICK_FAST_NS / CLK_PERIOD_NS);

    // status from the download and bus-master engines
    typedef struct packed {
        logic download_active;
        logic download_done;
        logic target_abort_evt;
        logic master_abort_evt;
        logic ptr_load;
        logic [31:0] ptr_value;
        logic mwi_wanted;
        logic priority_request;
        logic [FREE_W-1:0] fifo_free_units;
    } bmd_engine_s;

    // control toward the engines
    typedef struct packed {
        logic download_bus_request;
        logic use_mwi;
        logic transfers_enabled;
        logic download_stall;
        logic download_reset;
        logic list_empty;
        logic [31:0] list_pointer;
    } bmd_ctrl_s;
endpackage

// *** verilog/bmd_tick_gen.sv ***
// timer tick prescaler, slow or fast rate
`timescale 1ns/1ps
module bmd_tick_gen
    import bmd_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // rate select and tick
    input wire logic rate_fast,
    output logic tick
);
    logic [PRESCALE_W-1:0] cnt_reg;
    logic [PRESCALE_W-1:0] cnt_next;
    logic [PRESCALE_W-1:0] reload;
    logic wrap;

    assign reload = rate_fast ? (TICK_FAST_CYC - 9'h001) : (TICK_SLOW_CYC - 9'h001);
    assign wrap = (cnt_reg == '0) || (cnt_reg > reload);
    assign cnt_next = wrap ? reload : cnt_reg - 9'h001;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= '0;
            tick <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            tick <= wrap;
        end
    end

    ////////////////////////////////////////////////////////////////
    logic [PRESCALE_W-1:0] gap_reg;
    logic steady_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_reg <= '0;
            steady_reg <= 1'b0;
        end else begin
            gap_reg <= tick ? '0 : gap_reg + 9'h001;
            steady_reg <= ($past(rate_fast) != rate_fast) ? 1'b0 : (tick ? 1'b1 : steady_reg);
        end
    end

    tick_period_a: assert property (@(posedge pclk) disable iff (!presetn)
        tick && steady_reg && rate_fast == $past(rate_fast, 400) && $stable(rate_fast)
        |-> gap_reg == (rate_fast ? TICK_FAST_CYC : TICK_SLOW_CYC) - 9'h001)
        else $error("timer tick spacing wrong");
endmodule
